/* hw/discoverable_param_table_pkg.sv */
// Summary of operation
// - Accepted reset aborts work, restores power-on state
// - Accepted reset clears every volatile setting unless vol_set loads them in the same cycle
// - Reset needs 66H frame then 99H frame
// - Commands ignored during reset recovery period
// - Host checks busy and suspend before reset; host_cmd_end sends both reset frames without checking either
// - Opcode 5AH reads read-only parameter table
// - Signature, revision 1.0, one extra header
// - Bytes 07H, 0FH, 17H always FFH
// - First header: ID 00H, 9 dwords, 30H
// - Second header: maker ID, 3 dwords, 60H
// - Byte 30H E5H, byte 31H 20H
// - Byte 32H F1H, byte 33H FFH
// - Byte 38H 44H, byte 39H EBH
// - Byte 3AH 08H, byte 3BH 6BH
`default_nettype none
package discoverable_param_table_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int T_RST_US = 30;
  localparam int RST_CYCLES_DEF = T_RST_US * CLK_MHZ;
  localparam int SCK_HALF = 8;
  localparam logic [3:0] PH_RISE = 4'(SCK_HALF - 1);
  localparam logic [3:0] PH_END = 4'(2 * SCK_HALF - 1);
  localparam logic [5:0] GAP_CYCLES = 6'(2 * SCK_HALF);
  // ************************************************************
  // Frame layout and opcodes
  // ************************************************************
  localparam logic [7:0] OP_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_TABLE = 8'h5A;
  localparam logic [5:0] LAST_CMD_BIT = 6'd7;
  localparam logic [5:0] LAST_ADDR_BIT = 6'd31;
  localparam logic [5:0] LAST_DUMMY_BIT = 6'd39;
  localparam logic [5:0] CMD_BITS = 6'd8;
  localparam logic [5:0] TABLE_FRAME_BITS = 6'd40;
  localparam int FIFO_DEPTH = 8;
  // ************************************************************
  // Host command port map
  // ************************************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TADDR = 3'h1;
  localparam logic [2:0] REG_COUNT = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_DATA = 3'h4;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_TABLE_BIT = 1;
  // ************************************************************
  // Volatile state
  // ************************************************************
  typedef struct packed {
    logic write_latch;
    logic write_in_progress;
    logic suspend_flag;
    logic [7:0] read_param_bits;
    logic [7:0] continuous_read_bits;
    logic [2:0] wrap_setting_bits;
  } vol_s;
  localparam vol_s VOL_RESET = '0;
  // ************************************************************
  // Parameter table contents
  // ************************************************************
  localparam logic [4:0] MFR_IDX = 5'h10;
  localparam logic [7:0] HDR_TBL [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] BASIC_TBL [0:11] = '{
    8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
    8'h44, 8'hEB, 8'h08, 8'h6B};

  function automatic logic [7:0] tbl_byte(input logic [23:0] a, input logic [7:0] mfr);
    logic [7:0] b;
    b = 8'hFF;
    if (a[23:5] == 19'h0 && a[4:0] < 5'd24) begin
      b = (a[4:0] == MFR_IDX) ? mfr : HDR_TBL[a[4:0]];
    end else if (a[23:4] == 20'h3 && a[3:0] < 4'd12) begin
      b = BASIC_TBL[a[3:0]];
    end
    return b;
  endfunction
endpackage
`default_nettype wire

/* hw/flash_cmd_end.sv */
`default_nettype none
module flash_cmd_end
  import discoverable_param_table_pkg::*;
#(
  parameter int RST_CYCLES = RST_CYCLES_DEF,
  // Arbitrary maker code
  parameter logic [7:0] MFR_ID = 8'h5A
) (
  input wire logic clk,
  input wire logic reset,
  spi_link_if.flash link,
  input wire logic vol_set,
  input wire vol_s vol_in,
  output vol_s vol_out,
  output logic busy,
  output logic abort_op
);
  typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_SKIP} dev_state_e;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Link pins come from another clock; only stage two is read.
  logic [1:0] sck_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] mosi_s_q;
  logic sck_prev_q;
  logic cs_prev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_s_q <= 2'b00;
      cs_s_q <= 2'b11;
      mosi_s_q <= 2'b00;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], link.sck};
      cs_s_q <= {cs_s_q[0], link.cs_n};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      sck_prev_q <= sck_s_q[1];
      cs_prev_q <= cs_s_q[1];
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic deselected;
  logic mosi_bit;

  assign sck_rise = sck_s_q[1] & ~sck_prev_q;
  assign sck_fall = ~sck_s_q[1] & sck_prev_q;
  assign cs_rise = cs_s_q[1] & ~cs_prev_q;
  assign deselected = cs_s_q[1];
  assign mosi_bit = mosi_s_q[1];

  // ************************************************************
  // Command decoder state
  // ************************************************************
  dev_state_e st_q;
  dev_state_e st_d;
  logic [5:0] bits_q;
  logic [5:0] bits_d;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [2:0] obit_q;
  logic [2:0] obit_d;
  logic miso_q;
  logic miso_d;
  logic armed_q;
  logic armed_d;
  logic [15:0] rcnt_q;
  logic [15:0] rcnt_d;
  vol_s vol_q;
  vol_s vol_d;
  logic abort_q;
  logic abort_d;

  logic [7:0] cmd_now;
  logic [23:0] addr_now;
  logic [23:0] addr_next;

  assign cmd_now = {sh_q[6:0], mosi_bit};
  assign addr_now = {sh_q[22:0], mosi_bit};
  assign addr_next = addr_q + 24'h00_0001;

  always_comb begin
    st_d = st_q;
    bits_d = bits_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    out_d = out_q;
    obit_d = obit_q;
    miso_d = miso_q;
    armed_d = armed_q;
    rcnt_d = rcnt_q;
    vol_d = vol_q;
    abort_d = 1'b0;
    if (rcnt_q != 16'h0000) begin
      rcnt_d = rcnt_q - 16'h0001;
    end
    if (deselected) begin
      st_d = S_CMD;
      bits_d = 6'd0;
      obit_d = 3'd0;
      miso_d = 1'b0;
      if (cs_rise) begin
        // Any frame other than a bare arm opcode outside recovery disarms.
        armed_d = 1'b0;
        if (bits_q == CMD_BITS && rcnt_q == 16'h0000) begin
          if (cmd_q == OP_ARM) begin
            armed_d = 1'b1;
          end else if (cmd_q == OP_RESET && armed_q) begin
            rcnt_d = 16'(RST_CYCLES);
            vol_d = VOL_RESET;
            abort_d = 1'b1;
          end
        end
      end
    end else if (sck_rise) begin
      sh_d = addr_now;
      if (bits_q != 6'd63) begin
        bits_d = bits_q + 6'd1;
      end
      unique case (st_q)
        S_CMD: begin
          if (bits_q == LAST_CMD_BIT) begin
            cmd_d = cmd_now;
            if (rcnt_q != 16'h0000) begin
              st_d = S_SKIP;
            end else if (cmd_now == OP_TABLE) begin
              st_d = S_ADDR;
            end
          end
        end
        S_ADDR: begin
          if (bits_q == LAST_ADDR_BIT) begin
            addr_d = addr_now;
            st_d = S_DUMMY;
          end
        end
        S_DUMMY: begin
          if (bits_q == LAST_DUMMY_BIT) begin
            out_d = tbl_byte(addr_q, MFR_ID);
            st_d = S_DATA;
          end
        end
        S_DATA: begin
        end
        S_SKIP: begin
        end
      endcase
    end else if (sck_fall && st_q == S_DATA) begin
      miso_d = out_q[7];
      out_d = {out_q[6:0], 1'b1};
      obit_d = obit_q + 3'd1;
      if (obit_q == 3'd7) begin
        // Address runs on while select stays low.
        addr_d = addr_next;
        out_d = tbl_byte(addr_next, MFR_ID);
      end
    end
    // Outside logic loading a setting wins over a same-cycle clear.
    if (vol_set) begin
      vol_d = vol_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= S_CMD;
      bits_q <= 6'd0;
      sh_q <= 24'h00_0000;
      cmd_q <= 8'h00;
      addr_q <= 24'h00_0000;
      out_q <= 8'hFF;
      obit_q <= 3'd0;
      miso_q <= 1'b0;
      armed_q <= 1'b0;
      rcnt_q <= 16'h0000;
      vol_q <= VOL_RESET;
      abort_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      out_q <= out_d;
      obit_q <= obit_d;
      miso_q <= miso_d;
      armed_q <= armed_d;
      rcnt_q <= rcnt_d;
      vol_q <= vol_d;
      abort_q <= abort_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.miso = miso_q;
  assign link.miso_oe = ~deselected & (st_q == S_DATA);
  assign vol_out = vol_q;
  assign busy = (rcnt_q != 16'h0000);
  assign abort_op = abort_q;
endmodule
`default_nettype wire

/* hw/host_cmd_end.sv */
`default_nettype none
module byte_fifo
  import discoverable_param_table_pkg::*;
#(
  parameter int W = 8,
  parameter int D = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q;
  logic [AW:0] wp_d;
  logic [AW:0] rp_q;
  logic [AW:0] rp_d;
  logic push;
  logic pop;

  assign count = wp_q - rp_q;
  assign in_ready = (count != (AW+1)'(D));
  assign out_valid = (wp_q != rp_q);
  assign out_data = mem_q[rp_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module host_cmd_end
  import discoverable_param_table_pkg::*;
#(
  parameter int RST_CYCLES = RST_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  spi_link_if.host link,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP, H_WAIT} host_state_e;

  // ************************************************************
  // Receive buffer
  // ************************************************************
  logic [1:0] miso_s_q;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out;
  logic [3:0] fifo_count;
  logic [7:0] rxsh_q;
  logic pop;

  byte_fifo #(.W(8), .D(FIFO_DEPTH)) rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(rxsh_q),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .count(fifo_count)
  );

  // ************************************************************
  // Frame engine
  // ************************************************************
  host_state_e st_q;
  host_state_e st_d;
  logic [39:0] tx_q;
  logic [39:0] tx_d;
  logic [5:0] nbits_q;
  logic [5:0] nbits_d;
  logic [7:0] rxn_q;
  logic [7:0] rxn_d;
  logic [3:0] rxb_q;
  logic [3:0] rxb_d;
  logic [7:0] rxsh_d;
  logic [3:0] ph_q;
  logic [3:0] ph_d;
  logic [5:0] gap_q;
  logic [5:0] gap_d;
  logic [1:0] seq_q;
  logic [1:0] seq_d;
  logic [15:0] wcnt_q;
  logic [15:0] wcnt_d;
  logic cs_n_q;
  logic cs_n_d;
  logic sck_q;
  logic sck_d;
  logic [23:0] taddr_q;
  logic [23:0] taddr_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic idle;

  assign idle = (st_q == H_IDLE);
  assign pop = rd && addr == REG_DATA;

  always_comb begin
    st_d = st_q;
    tx_d = tx_q;
    nbits_d = nbits_q;
    rxn_d = rxn_q;
    rxb_d = rxb_q;
    rxsh_d = rxsh_q;
    ph_d = ph_q;
    gap_d = gap_q;
    seq_d = seq_q;
    wcnt_d = wcnt_q;
    cs_n_d = cs_n_q;
    sck_d = sck_q;
    taddr_d = taddr_q;
    count_d = count_q;
    fifo_valid = 1'b0;
    rdata_d = 32'h0000_0000;
    if (wr && addr == REG_TADDR) begin
      taddr_d = wdata[23:0];
    end
    if (wr && addr == REG_COUNT) begin
      count_d = wdata[7:0];
    end
    if (rd) begin
      unique case (addr)
        REG_TADDR: rdata_d = {8'h00, taddr_q};
        REG_COUNT: rdata_d = {24'h00_0000, count_q};
        REG_STATUS: rdata_d = {27'h000_0000, fifo_count, ~idle};
        REG_DATA: rdata_d = {23'h00_0000, fifo_out_valid, fifo_out};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    unique case (st_q)
      H_IDLE: begin
        ph_d = 4'd0;
        rxb_d = 4'd0;
        if (wr && addr == REG_CTRL && wdata[CTRL_RESET_BIT]) begin
          tx_d = {OP_ARM, 32'h0000_0000};
          nbits_d = CMD_BITS;
          rxn_d = 8'h00;
          seq_d = 2'd1;
          cs_n_d = 1'b0;
          st_d = H_SHIFT;
        end else if (wr && addr == REG_CTRL && wdata[CTRL_TABLE_BIT]) begin
          tx_d = {OP_TABLE, taddr_q, 8'h00};
          nbits_d = TABLE_FRAME_BITS;
          rxn_d = count_q;
          seq_d = 2'd0;
          cs_n_d = 1'b0;
          st_d = H_SHIFT;
        end
      end
      H_SHIFT: begin
        ph_d = ph_q + 4'd1;
        if (ph_q == PH_RISE) begin
          sck_d = 1'b1;
          if (nbits_q == 6'd0) begin
            rxsh_d = {rxsh_q[6:0], miso_s_q[1]};
            rxb_d = rxb_q + 4'd1;
          end
        end
        if (ph_q == PH_END) begin
          sck_d = 1'b0;
          ph_d = 4'd0;
          if (nbits_q != 6'd0) begin
            tx_d = {tx_q[38:0], 1'b0};
            nbits_d = nbits_q - 6'd1;
            if (nbits_q == 6'd1 && rxn_q == 8'h00) begin
              cs_n_d = 1'b1;
              st_d = H_GAP;
            end
          end else if (rxb_q == 4'd8) begin
            // Full buffer holds the clock until software drains it.
            fifo_valid = 1'b1;
            if (!fifo_ready) begin
              ph_d = ph_q;
            end else begin
              rxb_d = 4'd0;
              rxn_d = rxn_q - 8'h01;
              if (rxn_q == 8'h01) begin
                cs_n_d = 1'b1;
                st_d = H_GAP;
              end
            end
          end
        end
      end
      H_GAP: begin
        gap_d = gap_q + 6'd1;
        if (gap_q == GAP_CYCLES) begin
          gap_d = 6'd0;
          st_d = H_IDLE;
          if (seq_q == 2'd1) begin
            tx_d = {OP_RESET, 32'h0000_0000};
            nbits_d = CMD_BITS;
            seq_d = 2'd2;
            cs_n_d = 1'b0;
            st_d = H_SHIFT;
          end else if (seq_q == 2'd2) begin
            wcnt_d = 16'(RST_CYCLES);
            seq_d = 2'd0;
            st_d = H_WAIT;
          end
        end
      end
      H_WAIT: begin
        wcnt_d = wcnt_q - 16'h0001;
        if (wcnt_q == 16'h0001) begin
          st_d = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      miso_s_q <= 2'b00;
      st_q <= H_IDLE;
      tx_q <= 40'h00_0000_0000;
      nbits_q <= 6'd0;
      rxn_q <= 8'h00;
      rxb_q <= 4'd0;
      rxsh_q <= 8'h00;
      ph_q <= 4'd0;
      gap_q <= 6'd0;
      seq_q <= 2'd0;
      wcnt_q <= 16'h0000;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      taddr_q <= 24'h00_0000;
      count_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      miso_s_q <= {miso_s_q[0], link.miso};
      st_q <= st_d;
      tx_q <= tx_d;
      nbits_q <= nbits_d;
      rxn_q <= rxn_d;
      rxb_q <= rxb_d;
      rxsh_q <= rxsh_d;
      ph_q <= ph_d;
      gap_q <= gap_d;
      seq_q <= seq_d;
      wcnt_q <= wcnt_d;
      cs_n_q <= cs_n_d;
      sck_q <= sck_d;
      taddr_q <= taddr_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.mosi = tx_q[39];
  assign rdata = rdata_q;
endmodule
`default_nettype wire

/* hw/spi_link_if.sv */
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport flash (input cs_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

/* verification/soft_reset_and_param_table_props.sv */
`default_nettype none
module soft_reset_and_param_table_props
  import discoverable_param_table_pkg::*;
#(
  parameter int RST_CYCLES = RST_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic busy,
  input wire logic abort_op,
  input wire vol_s vol_out
);
  // ********************
  // Helper counters
  // ********************
  logic sck_q;
  logic sck_d;
  logic [11:0] rise_q;
  logic [11:0] rise_d;
  logic [15:0] busy_q;
  logic [15:0] busy_d;

  // Rise count saturates so a very long frame cannot wrap back under 40
  always_comb begin
    sck_d = sck;
    rise_d = rise_q;
    if (cs_n) begin
      rise_d = '0;
    end else if (sck && !sck_q && rise_q != 12'hFFF) begin
      rise_d = rise_q + 12'h001;
    end
    busy_d = busy ? busy_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_q <= 1'b0;
      rise_q <= '0;
      busy_q <= '0;
    end else begin
      sck_q <= sck_d;
      rise_q <= rise_d;
      busy_q <= busy_d;
    end
  end

  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moved outside a frame");
  // Select reaches the flash through two flops, so its view lags by two cycles
  oe_framed_a: assert property (miso_oe |-> !$past(cs_n, 2))
    else $error("data driven without select");
  oe_after_dummy_a: assert property (miso_oe && !cs_n |-> rise_q >= 12'h028)
    else $error("data driven before opcode, address and dummy");
  busy_silent_a: assert property (busy |-> !miso_oe)
    else $error("answered a command during recovery");
  abort_pulse_a: assert property (abort_op |=> !abort_op)
    else $error("abort longer than one cycle");
  abort_idle_a: assert property (abort_op |-> cs_n)
    else $error("reset accepted inside a frame");
  abort_clears_a: assert property (abort_op |=> vol_out == VOL_RESET)
    else $error("volatile settings kept after reset");
  abort_busy_a: assert property (abort_op |=> busy)
    else $error("no recovery after reset");
  busy_length_a: assert property ($fell(busy) |-> busy_q == 16'(RST_CYCLES))
    else $error("recovery period has wrong length");
  busy_cause_a: assert property ($rose(busy) |-> abort_op || $past(abort_op))
    else $error("recovery without an accepted reset");
endmodule
`default_nettype wire

/* verification/soft_reset_and_param_table_test.sv */
`default_nettype none
module soft_reset_and_param_table_test
  import discoverable_param_table_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Setup
  // ********************
  localparam int RST_SIM = 20;
  // Arbitrary maker code
  localparam logic [7:0] MFR_SIM = 8'hA7;
  localparam logic [7:0] HDR_EXP [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    MFR_SIM, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] BASIC_EXP [0:11] = '{
    8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
    8'h44, 8'hEB, 8'h08, 8'h6B};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic vol_set = 1'b0;
  vol_s vol_in = VOL_RESET;
  vol_s vol_out;
  logic busy;
  logic abort_op;
  int n_errors = 0;
  int check_count = 0;

  spi_link_if spi_link_if_inst ();
  flash_cmd_end #(.RST_CYCLES(RST_SIM), .MFR_ID(MFR_SIM)) flash_cmd_end_inst (.clk(clk), .reset(reset),
    .link(spi_link_if_inst.flash), .vol_set(vol_set), .vol_in(vol_in), .vol_out(vol_out), .busy(busy),
    .abort_op(abort_op));
  host_cmd_end #(.RST_CYCLES(RST_SIM)) host_cmd_end_inst (.clk(clk), .reset(reset),
    .link(spi_link_if_inst.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  soft_reset_and_param_table_props #(.RST_CYCLES(RST_SIM)) props_inst (.clk(clk), .reset(reset),
    .cs_n(spi_link_if_inst.cs_n), .sck(spi_link_if_inst.sck), .mosi(spi_link_if_inst.mosi),
    .miso(spi_link_if_inst.miso), .miso_oe(spi_link_if_inst.miso_oe), .busy(busy), .abort_op(abort_op),
    .vol_out(vol_out));

  always #2 clk = ~clk;

  // ********************
  // Shared tasks
  // ********************
  task automatic fail(input string msg);
    n_errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("value %h, expected %h", got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic bus_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [7:0] exp_byte(input int a);
    if (a < 24) return HDR_EXP[a];
    if (a >= 48 && a < 60) return BASIC_EXP[a - 48];
    return 8'hFF;
  endfunction

  // ********************
  // Scenarios
  // ********************
  task automatic regs_scn();
    logic [31:0] d;
    check_bit(spi_link_if_inst.cs_n, 1'b1);
    bus_write(REG_TADDR, 32'h0012_3456);
    bus_read(REG_TADDR, d);
    check_word(d, 32'h0012_3456);
    bus_read(3'h7, d);
    check_word(d, 32'h0000_0000);
    @(posedge clk);
    #1 check_word(rdata, 32'h0000_0000);
  endtask

  // Long waits first so the buffer fills and the link has to stall
  task automatic table_scn(input int start, input int n);
    logic [31:0] d;
    int got;
    int guard;
    bus_write(REG_TADDR, 32'(start));
    bus_write(REG_COUNT, 32'(n));
    bus_write(REG_CTRL, 32'h0000_0002);
    repeat (2500) @(posedge clk);
    bus_read(REG_STATUS, d);
    if (n >= FIFO_DEPTH) check_word(32'(d[4:1]), 32'(FIFO_DEPTH));
    got = 0;
    guard = 0;
    while (got < n && guard < 20000) begin
      bus_read(REG_DATA, d);
      guard++;
      if (d[8] === 1'b1) begin
        check_word(32'(d[7:0]), 32'(exp_byte(start + got)));
        got++;
      end
    end
    if (got < n) fail("table bytes missing");
    bus_read(REG_DATA, d);
    check_bit(d[8], 1'b0);
    guard = 0;
    while (spi_link_if_inst.cs_n !== 1'b1 && guard < 200) begin
      @(posedge clk);
      guard++;
    end
    check_bit(spi_link_if_inst.cs_n, 1'b1);
    repeat (40) @(posedge clk);
  endtask

  task automatic reset_scn();
    vol_s v;
    logic [31:0] d;
    int k;
    int low;
    v = vol_s'(22'h3F_FFFF);
    // Never reset during a program, erase or suspend
    v.write_in_progress = 1'b0;
    v.suspend_flag = 1'b0;
    @(posedge clk);
    vol_in <= v;
    vol_set <= 1'b1;
    @(posedge clk);
    vol_set <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check_word(32'(vol_out), 32'(v));
    check_bit(vol_out.write_in_progress | vol_out.suspend_flag, 1'b0);
    bus_write(REG_CTRL, 32'h0000_0001);
    k = 0;
    while (abort_op !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    check_bit(abort_op, 1'b1);
    @(posedge clk);
    #1 check_word(32'(vol_out), 32'(VOL_RESET));
    check_bit(busy, 1'b1);
    bus_write(REG_CTRL, 32'h0000_0002);
    low = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (spi_link_if_inst.cs_n !== 1'b1) low++;
    end
    check_word(32'(low), 32'h0000_0000);
    k = 0;
    d = 32'h0000_0001;
    while (d[0] !== 1'b0 && k < 200) begin
      bus_read(REG_STATUS, d);
      k++;
    end
    check_bit(d[0], 1'b0);
    check_bit(busy, 1'b0);
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // About five times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    fail("watchdog expired");
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    regs_scn();
    table_scn(0, 24);
    reset_scn();
    table_scn(48, 12);
    results();
  end
endmodule
`default_nettype wire
